// File: src/sfpc_pkg.sv
// Constants for the switch frame policy configuration block
package sfpc_pkg;
    // Printed register offsets are indices; byte address is four times the index
    localparam logic [7:0] GC2_IDX       = 8'h04;
    localparam logic [7:0] GC3_IDX       = 8'h05;
    localparam logic [7:0] GC2_ADDR      = GC2_IDX * 8'h04;
    localparam logic [7:0] GC3_ADDR      = GC3_IDX * 8'h04;
    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned REG_W        = 8;
    // Global control two fields
    localparam int unsigned GC2_HUGE_BIT  = 2;
    localparam int unsigned GC2_LEGAL_BIT = 1;
    localparam logic [7:0]  GC2_RW_MASK   = 8'h07;
    localparam logic [7:0]  GC2_RESET     = 8'h00;
    // Global control three fields
    localparam int unsigned GC3_VLAN_BIT  = 7;
    localparam int unsigned GC3_IGMP_BIT  = 6;
    localparam int unsigned GC3_WFQ_BIT   = 3;
    localparam int unsigned GC3_SNIFF_BIT = 0;
    localparam logic [7:0]  GC3_RW_MASK   = 8'hC9;
    localparam logic [7:0]  GC3_RESET     = 8'h00;
    // Frame size limits in bytes, inclusive
    localparam int unsigned LEN_W         = 11;
    localparam logic [10:0] LEN_HUGE      = 11'h77C;
    localparam logic [10:0] LEN_DEFAULT   = 11'h600;
    localparam logic [10:0] LEN_TAGGED    = 11'h5F2;
    localparam logic [10:0] LEN_UNTAGGED  = 11'h5EE;
    // Ports: bit 2 is the processor-facing MII port
    localparam int unsigned NUM_PORTS     = 3;
    localparam logic [2:0]  CPU_PORT_MASK = 3'h4;
    // Egress queues and weights, queue 3 highest
    localparam int unsigned NUM_Q         = 4;
    localparam int unsigned CRED_W        = 4;
    localparam logic [3:0]  WFQ_W3        = 4'h8;
    localparam logic [3:0]  WFQ_W2        = 4'h4;
    localparam logic [3:0]  WFQ_W1        = 4'h2;
    localparam logic [3:0]  WFQ_W0        = 4'h1;
    localparam logic [3:0]  WFQ_BONUS     = 4'h1;
    localparam logic [3:0]  CRED_ZERO     = 4'h0;
    localparam logic [3:0]  CRED_ONE      = 4'h1;
    // Decision buffer
    localparam logic [1:0]  BUF_DEPTH     = 2'h2;
    localparam logic [1:0]  CNT_ONE       = 2'h1;
endpackage

// File: src/sfpc_top.sv
// Frame policy configuration registers, size filter, sniff rule and egress scheduler
//
// What this block does
// [R1] Huge bit set: accept frames up to 1916 bytes, legal check ignored.
// [R2] Both bits clear: accept frames up to 1536 bytes.
// [R3] Legal check only: drop tagged above 1522, untagged above 1518 bytes.
// [R4] Software keeps reserved bits at reset value; reserved bit 0 resets 0.
// [R5] Global control three bit 7 enables VLAN mode; resets disabled.
// [R6] IGMP snoop bit set: every IGMP frame within the size limit goes to processor port.
// [R7] Fair queue bit clear: egress follows the per-port priority method.
// [R8] Fair queuing with all queues busy: bandwidth 8:4:2:1, queue three first.
// [R9] With empty queues, highest non-empty queue gets one extra weight.
// [R10] Sniff mode set: sniff only when source and destination both match.
// [R11] Sniff mode clear: sniff when source or destination matches.
// [R12] Oversize frames are discarded entirely; tag flag comes from parsed header.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
module sfpc_top (
    input  wire logic                          core_clk_in,
    input  wire logic                          rst_n_in,
    input  wire logic                          ce_in,
    input  wire logic                          psel_in,
    input  wire logic                          penable_in,
    input  wire logic                          pwrite_in,
    input  wire logic [sfpc_pkg::ADDR_W-1:0]   paddr_in,
    input  wire logic [sfpc_pkg::DATA_W-1:0]   pwdata_in,
    input  wire logic [3:0]                    pstrb_in,
    output logic      [sfpc_pkg::DATA_W-1:0]   prdata_out,
    output logic                               pready_out,
    output logic                               pslverr_out,
    input  wire logic                          frm_valid_in,
    output logic                               frm_ready_out,
    input  wire logic [sfpc_pkg::LEN_W-1:0]    frm_len_in,
    input  wire logic                          frm_tagged_in,
    input  wire logic                          frm_igmp_in,
    input  wire logic                          frm_src_sniff_in,
    input  wire logic                          frm_dst_sniff_in,
    input  wire logic [sfpc_pkg::NUM_PORTS-1:0] frm_ports_in,
    output logic                               dec_valid_out,
    input  wire logic                          dec_ready_in,
    output logic      [sfpc_pkg::NUM_PORTS-1:0] dec_fwd_mask_out,
    output logic                               dec_sniff_out,
    output logic                               dec_drop_out,
    output logic                               vlan_en_out,
    output logic                               wfq_en_out,
    input  wire logic [sfpc_pkg::NUM_Q-1:0]    q_nonempty_in,
    input  wire logic                          q_take_in,
    output logic      [1:0]                    q_sel_out,
    output logic                               q_sel_valid_out
);
    import sfpc_pkg::*;

    logic [REG_W-1:0]  gc2_q;
    logic [REG_W-1:0]  gc3_q;
    logic [DATA_W-1:0] prdata_q;
    logic              slverr_q;
    logic              hit_gc2;
    logic              hit_gc3;
    logic              acc;
    logic              wr_lane0;
    logic [REG_W-1:0]  rd_mux;

    // APB slave
    assign hit_gc2  = (paddr_in == GC2_ADDR);
    assign hit_gc3  = (paddr_in == GC3_ADDR);
    assign acc      = psel_in & penable_in & ce_in;
    assign wr_lane0 = acc & pwrite_in & pstrb_in[0];
    assign rd_mux   = hit_gc2 ? gc2_q : (hit_gc3 ? gc3_q : 8'h00);

    // Zero wait states; a frozen clock enable stretches the access
    assign pready_out  = acc;
    assign pslverr_out = acc & slverr_q;
    assign prdata_out  = prdata_q;

    // Read data captured in the setup cycle so it leaves a flop
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else if (ce_in && psel_in && !penable_in) begin
            prdata_q <= {24'h00_0000, rd_mux};
            slverr_q <= ~(hit_gc2 | hit_gc3);
        end
    end

    // Reserved bits other than global control two bit 0 are not stored, so they read back zero
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gc2_q <= GC2_RESET;                                   // [R4]
            gc3_q <= GC3_RESET;                                   // [R5]
        end else if (wr_lane0) begin
            if (hit_gc2) begin
                gc2_q <= pwdata_in[REG_W-1:0] & GC2_RW_MASK;
            end
            if (hit_gc3) begin
                gc3_q <= pwdata_in[REG_W-1:0] & GC3_RW_MASK;
            end
        end
    end

    assign vlan_en_out = gc3_q[GC3_VLAN_BIT];                    // [R5]
    assign wfq_en_out  = gc3_q[GC3_WFQ_BIT];

    // Frame decision
    logic [LEN_W-1:0]     len_limit;
    logic                 drop_d;
    logic [NUM_PORTS-1:0] mask_d;
    logic                 sniff_d;

    always_comb begin
        if (gc2_q[GC2_HUGE_BIT]) begin
            len_limit = LEN_HUGE;                                 // [R1]
        end else if (gc2_q[GC2_LEGAL_BIT]) begin
            len_limit = frm_tagged_in ? LEN_TAGGED : LEN_UNTAGGED; // [R3] [R12]
        end else begin
            len_limit = LEN_DEFAULT;                              // [R2]
        end
    end

    assign drop_d = (frm_len_in > len_limit);
    // Discarded frames reach no port and are never mirrored
    assign mask_d = drop_d ? 3'h0 :                              // [R12]
                    ((gc3_q[GC3_IGMP_BIT] & frm_igmp_in) ? CPU_PORT_MASK : frm_ports_in); // [R6]
    assign sniff_d = ~drop_d & (gc3_q[GC3_SNIFF_BIT] ?
                     (frm_src_sniff_in & frm_dst_sniff_in) :     // [R10]
                     (frm_src_sniff_in | frm_dst_sniff_in));     // [R11]

    // Two-entry decision buffer
    logic [NUM_PORTS-1:0] buf_mask_q  [2];
    logic                 buf_sniff_q [2];
    logic                 buf_drop_q  [2];
    logic                 wr_ptr_q;
    logic                 rd_ptr_q;
    logic [1:0]           cnt_q;
    logic                 push;
    logic                 pop;

    assign frm_ready_out = (cnt_q != BUF_DEPTH);
    assign dec_valid_out = (cnt_q != 2'h0);
    assign push = frm_valid_in & frm_ready_out & ce_in;
    assign pop  = dec_valid_out & dec_ready_in & ce_in;

    assign dec_fwd_mask_out = buf_mask_q[rd_ptr_q];
    assign dec_sniff_out    = buf_sniff_q[rd_ptr_q];
    assign dec_drop_out     = buf_drop_q[rd_ptr_q];

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < 2; i++) begin
                buf_mask_q[i]  <= 3'h0;
                buf_sniff_q[i] <= 1'b0;
                buf_drop_q[i]  <= 1'b0;
            end
        end else if (push) begin
            buf_mask_q[wr_ptr_q]  <= mask_d;
            buf_sniff_q[wr_ptr_q] <= sniff_d;
            buf_drop_q[wr_ptr_q]  <= drop_d;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            cnt_q    <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + CNT_ONE;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - CNT_ONE;
            end
        end
    end

    // Egress scheduler
    logic [CRED_W-1:0] cred_q [NUM_Q];
    logic [NUM_Q-1:0]  elig;
    logic              any_elig;
    logic              any_busy;
    logic              any_empty;
    logic [1:0]        top_busy;
    logic [1:0]        pick;
    logic [CRED_W-1:0] weight [NUM_Q];
    logic              reload;

    assign weight[3] = WFQ_W3;                                    // [R8]
    assign weight[2] = WFQ_W2;
    assign weight[1] = WFQ_W1;
    assign weight[0] = WFQ_W0;

    always_comb begin
        elig     = 4'h0;
        top_busy = 2'h0;
        pick     = 2'h0;
        for (int i = 0; i < NUM_Q; i++) begin
            elig[i] = q_nonempty_in[i] & (cred_q[i] != CRED_ZERO);
            if (q_nonempty_in[i]) begin
                top_busy = 2'(i);
            end
            if (elig[i]) begin
                pick = 2'(i);
            end
        end
    end

    assign any_elig  = |elig;
    assign any_busy  = |q_nonempty_in;
    assign any_empty = ~&q_nonempty_in;
    assign reload    = wfq_en_out & any_busy & ~any_elig;

    // A round ends when no busy queue has credit left; refill weights then
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < NUM_Q; i++) begin
                cred_q[i] <= CRED_ZERO;
            end
        end else if (ce_in) begin
            if (reload) begin
                for (int i = 0; i < NUM_Q; i++) begin
                    cred_q[i] <= weight[i] +                       // [R8]
                                 ((any_empty && top_busy == 2'(i)) ? WFQ_BONUS : CRED_ZERO); // [R9]
                end
            end else if (wfq_en_out && q_take_in && q_sel_valid_out && cred_q[q_sel_out] != CRED_ZERO) begin
                cred_q[q_sel_out] <= cred_q[q_sel_out] - CRED_ONE;
            end
        end
    end

    // Strict pick when fair queuing is off; per-port method applied downstream
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q_sel_out       <= 2'h0;
            q_sel_valid_out <= 1'b0;
        end else if (ce_in) begin
            q_sel_out       <= wfq_en_out ? pick : top_busy;      // [R7]
            q_sel_valid_out <= wfq_en_out ? any_elig : any_busy;  // [R7]
        end
    end

    // Assertions
    property p_huge_accept;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (push && gc2_q[GC2_HUGE_BIT]) |-> (drop_d == (frm_len_in > 11'h77C));
    endproperty
    a_huge_accept: assert property (p_huge_accept) else $error("huge limit wrong"); // [R1]

    property p_default_limit;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (push && !gc2_q[GC2_HUGE_BIT] && !gc2_q[GC2_LEGAL_BIT]) ##1 ce_in |->
        (buf_drop_q[$past(wr_ptr_q)] == ($past(frm_len_in) > 11'h600));
    endproperty
    a_default_limit: assert property (p_default_limit) else $error("default limit wrong"); // [R2]

    property p_legal_limit;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (push && !gc2_q[GC2_HUGE_BIT] && gc2_q[GC2_LEGAL_BIT]) |->
        (drop_d == (frm_len_in > (frm_tagged_in ? 11'h5F2 : 11'h5EE)));
    endproperty
    a_legal_limit: assert property (p_legal_limit) else $error("legal limit wrong"); // [R3]

    property p_drop_nowhere;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        dec_valid_out && dec_drop_out |-> (dec_fwd_mask_out == 3'h0) && !dec_sniff_out;
    endproperty
    a_drop_nowhere: assert property (p_drop_nowhere) else $error("dropped frame forwarded"); // [R12]

    property p_igmp_cpu;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (push && !drop_d && frm_igmp_in && gc3_q[GC3_IGMP_BIT]) ##1 (dec_valid_out && rd_ptr_q == $past(wr_ptr_q))
        |-> dec_fwd_mask_out == CPU_PORT_MASK;
    endproperty
    a_igmp_cpu: assert property (p_igmp_cpu) else $error("igmp not sent to cpu port"); // [R6]

    property p_sniff_rule;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (push && !drop_d) |-> sniff_d == (gc3_q[GC3_SNIFF_BIT] ? (frm_src_sniff_in && frm_dst_sniff_in)
                                                                : (frm_src_sniff_in || frm_dst_sniff_in));
    endproperty
    a_sniff_rule: assert property (p_sniff_rule) else $error("sniff rule wrong"); // [R10] [R11]

    property p_vlan_write;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (wr_lane0 && hit_gc3) |=> vlan_en_out == $past(pwdata_in[GC3_VLAN_BIT]);
    endproperty
    a_vlan_write: assert property (p_vlan_write) else $error("vlan enable not written"); // [R5]

    property p_wfq_reload;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (reload && ce_in && &q_nonempty_in) |=>
        (cred_q[3] == 4'h8 && cred_q[2] == 4'h4 && cred_q[1] == 4'h2 && cred_q[0] == 4'h1);
    endproperty
    a_wfq_reload: assert property (p_wfq_reload) else $error("weights not 8:4:2:1"); // [R8]

    property p_wfq_bonus;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (reload && ce_in && q_nonempty_in == 4'hB) |=> cred_q[3] == 4'h9;
    endproperty
    a_wfq_bonus: assert property (p_wfq_bonus) else $error("no bonus weight"); // [R9]

    property p_strict_pick;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (ce_in && !wfq_en_out && q_nonempty_in[3]) |=> q_sel_valid_out && q_sel_out == 2'h3;
    endproperty
    a_strict_pick: assert property (p_strict_pick) else $error("strict pick wrong"); // [R7]

    property p_buf_full;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (push && !pop && cnt_q == 2'h1) |=> !frm_ready_out [*1] ##0 dec_valid_out;
    endproperty
    a_buf_full: assert property (p_buf_full) else $error("buffer full not shown");

    c_drop: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) pop && dec_drop_out);
    c_full: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) !frm_ready_out ##1 pop);
    c_reload: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) reload && any_empty);
    c_igmp: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) push && frm_igmp_in && !drop_d);
endmodule

// File: test/sfpc_bench.sv
// Self-checking bench for the frame policy configuration block
`timescale 1ns/1ns
module sfpc_bench;
    import sfpc_pkg::*;
    logic        clk;
    logic        rst_n;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        fv;
    logic        fr;
    logic [10:0] flen;
    logic        ftag;
    logic        figmp;
    logic        fsrc;
    logic        fdst;
    logic [2:0]  fports;
    logic        dv;
    logic        dr;
    logic [2:0]  dmask;
    logic        dsniff;
    logic        ddrop;
    logic        vlan_en;
    logic        wfq_en;
    logic [3:0]  qne;
    logic        qtake;
    logic [1:0]  qsel;
    logic        qsel_v;
    int          fails;
    int          total_checks;
    int          cycles;
    int          cnt[4];
    logic [31:0] rd;
    logic        er;
    logic [2:0]  m;
    logic        sn;
    logic        dp;
    logic [7:0]  g;

    sfpc_top DUT (.core_clk_in(clk), .rst_n_in(rst_n), .ce_in(ce), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .frm_valid_in(fv), .frm_ready_out(fr), .frm_len_in(flen),
        .frm_tagged_in(ftag), .frm_igmp_in(figmp), .frm_src_sniff_in(fsrc), .frm_dst_sniff_in(fdst),
        .frm_ports_in(fports), .dec_valid_out(dv), .dec_ready_in(dr), .dec_fwd_mask_out(dmask),
        .dec_sniff_out(dsniff), .dec_drop_out(ddrop), .vlan_en_out(vlan_en), .wfq_en_out(wfq_en),
        .q_nonempty_in(qne), .q_take_in(qtake), .q_sel_out(qsel), .q_sel_valid_out(qsel_v));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Ceiling well above the few hundred cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            fails++;
            end_of_test;
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer, then an idle cycle so psel is never assigned twice in a step
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] st);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge clk);
        penable <= 1'b1;
        // Waits for pready with no limit of its own; the bench timeout ends it if pready never rises
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
        apb(1'b0, a, 32'h0, 4'h0);
        check(rd, exp);
        check({31'h0, er}, {31'h0, experr});
    endtask

    // Returns at the taking edge; caller lets an edge pass before the next push
    task push(input logic [10:0] len, input logic tg, ig, s, d, input logic [2:0] pm);
        fv <= 1'b1;
        flen <= len;
        ftag <= tg;
        figmp <= ig;
        fsrc <= s;
        fdst <= d;
        fports <= pm;
        do begin
            @(posedge clk);
        end while (fr !== 1'b1);
        fv <= 1'b0;
    endtask

    task pop;
        do begin
            @(posedge clk);
        end while (dv !== 1'b1);
        m = dmask;
        sn = dsniff;
        dp = ddrop;
    endtask

    // Take every other cycle so the registered selection reflects the last debit
    task round(input int n);
        int k;
        k = 0;
        cnt = '{0, 0, 0, 0};
        while (n > 0 && k < 200) begin
            qtake <= 1'b1;
            @(posedge clk);
            if (qsel_v === 1'b1) begin
                cnt[qsel]++;
                n--;
            end
            qtake <= 1'b0;
            @(posedge clk);
            k++;
        end
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {fv, flen, ftag, figmp, fsrc, fdst, fports, qne, qtake} = '0;
        dr = 1'b1;
        ce = 1'b1;
        rst_n = 1'b0;
        fails = 0;
        total_checks = 0;
        cycles = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdchk(GC2_ADDR, 32'h0, 1'b0);
        rdchk(GC3_ADDR, 32'h0, 1'b0);
        check({30'h0, vlan_en, wfq_en}, 32'h0);
        apb(1'b1, GC2_ADDR, 32'hFFFF_FFFF, 4'hF);
        rdchk(GC2_ADDR, 32'h7, 1'b0);
        apb(1'b1, GC3_ADDR, 32'hFFFF_FFFF, 4'h0);
        rdchk(GC3_ADDR, 32'h0, 1'b0);
        apb(1'b1, GC3_ADDR, 32'hFFFF_FFFF, 4'hF);
        rdchk(GC3_ADDR, 32'hC9, 1'b0);
        check({30'h0, vlan_en, wfq_en}, 32'h3);
        apb(1'b1, 8'h18, 32'h5A, 4'hF);
        check({31'h0, er}, 32'h1);
        rdchk(8'h18, 32'h0, 1'b1);
        // Size filter boundaries for all four limit settings, tagged and not
        for (int gi = 0; gi < 4; gi++) begin
            g = 8'(gi * 2);
            apb(1'b1, GC2_ADDR, {24'h0, g}, 4'h1);
            apb(1'b1, GC3_ADDR, 32'h0, 4'h1);
            for (int j = 0; j < 8; j++) begin
                for (int t = 0; t < 2; t++) begin
                    logic [10:0] len;
                    logic [10:0] lim;
                    logic        ex;
                    len = (j < 2) ? 11'h5EE : (j < 4) ? 11'h5F2 : (j < 6) ? 11'h600 : 11'h77C;
                    len = len + 11'(j % 2);
                    lim = g[2] ? 11'h77C : g[1] ? (t == 1 ? 11'h5F2 : 11'h5EE) : 11'h600;
                    ex = len > lim;
                    push(len, t[0], 1'b0, 1'b1, 1'b1, 3'h3);
                    pop;
                    check({31'h0, dp}, {31'h0, ex});
                    check({29'h0, m}, ex ? 32'h0 : 32'h3);
                    check({31'h0, sn}, {31'h0, ~ex});
                end
            end
        end
        // Snoop and sniff combinations
        apb(1'b1, GC2_ADDR, 32'h0, 4'h1);
        for (int c = 0; c < 4; c++) begin
            g = {1'b0, c[1], 5'h0, c[0]};
            apb(1'b1, GC3_ADDR, {24'h0, g}, 4'h1);
            for (int v = 0; v < 8; v++) begin
                push(11'h040, 1'b0, v[2], v[1], v[0], 3'h3);
                pop;
                check({29'h0, m}, (g[6] && v[2]) ? 32'h4 : 32'h3);
                check({31'h0, sn}, {31'h0, g[0] ? (v[1] & v[0]) : (v[1] | v[0])});
            end
        end
        // Receiver stalls: two decisions held, third refused, order kept
        dr <= 1'b0;
        push(11'h040, 1'b0, 1'b0, 1'b0, 1'b0, 3'h1);
        @(posedge clk);
        push(11'h040, 1'b0, 1'b0, 1'b0, 1'b0, 3'h2);
        @(posedge clk);
        check({31'h0, fr}, 32'h0);
        dr <= 1'b1;
        pop;
        check({29'h0, m}, 32'h1);
        pop;
        check({29'h0, m}, 32'h2);
        // Egress scheduling
        apb(1'b1, GC3_ADDR, 32'h0, 4'h1);
        qne <= 4'h5;
        repeat (3) @(posedge clk);
        check({30'h0, qsel}, 32'h2);
        // Clock enable low freezes the selection although the queues change
        ce <= 1'b0;
        qne <= 4'h8;
        repeat (2) @(posedge clk);
        check({30'h0, qsel}, 32'h2);
        ce <= 1'b1;
        qne <= 4'hF;
        apb(1'b1, GC3_ADDR, 32'h08, 4'h1);
        round(15);
        check(cnt[3], 32'h8);
        check(cnt[2], 32'h4);
        check(cnt[1], 32'h2);
        check(cnt[0], 32'h1);
        // Old credits drain first; the bonus shows only after the next refill
        qne <= 4'hB;
        @(posedge clk);
        round(11);
        check(cnt[2], 32'h0);
        // Ten takes split 9:1 with the bonus, 8:2 without it
        round(10);
        check(cnt[3], 32'h9);
        check(cnt[1], 32'h1);
        check(cnt[0], 32'h0);
        end_of_test;
    end
endmodule
